// [src/sasp_defs.svh]
// timing and framing constants of the stereo audio serial port
// assumes inclusion by the design file and the bench only
`ifndef SASP_DEFS_SVH
`define SASP_DEFS_SVH

// system clock rate in kHz
`define SASP_SYS_CLK_KHZ   125000
// highest serial clock rate in kHz
`define SASP_SCK_MAX_KHZ   6200
// highest word select rate in Hz
`define SASP_WS_MAX_HZ     96000
// system clocks per serial clock half period, rounded up
`define SASP_SCK_HALF_CYC  ((`SASP_SYS_CLK_KHZ + 2*`SASP_SCK_MAX_KHZ - 1) / \
                            (2*`SASP_SCK_MAX_KHZ))
// significant bits per channel
`define SASP_SAMPLE_BITS   16
// serial clocks per channel slot
`define SASP_SLOT_BITS     32
// words held by each buffer
`define SASP_FIFO_DEPTH    16

`endif

// [src/sasp_pkg.sv]
// types of the stereo audio serial port
// assumes nothing beyond the constants header
package sasp_pkg;

    // framing format selected by the audio port configuration setting
    typedef enum logic [2:0] {
        SASP_FMT_I2S = 3'b001,
        SASP_FMT_LJ  = 3'b010,
        SASP_FMT_RJ  = 3'b100
    } sasp_fmt_t;

endpackage : sasp_pkg

// [src/sasp_top.sv]
// stereo audio serial port: buffers, clock generator and serial link
// assumes sck_i carries the wire level of the serial clock pin, also in
// master mode, and that configuration changes only while deselected
`timescale 1ns/1ns
`include "sasp_defs.svh"
`default_nettype none

module sasp_fifo #(
    parameter int W = 32,
    parameter int D = `SASP_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // filling side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // draining side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0]   cnt_ff;
    logic [AW:0]   nxt_cnt;
    logic          push;
    logic          pop;

    assign push = in_valid_i && in_ready_o;
    assign pop  = (cnt_ff != '0) && (!out_valid_o || out_ready_i);

    always_comb begin
        nxt_cnt = cnt_ff;
        if (push && !pop) begin
            nxt_cnt = cnt_ff + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_ff  <= '0;
            rd_ptr_ff  <= '0;
            cnt_ff     <= '0;
            in_ready_o <= 1'b0;
        end else begin
            if (push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
            if (pop)  rd_ptr_ff <= rd_ptr_ff + AW'(1);
            cnt_ff     <= nxt_cnt;
            in_ready_o <= nxt_cnt < DEPTH_C;
        end
    end

    // registered output stage, refilled whenever it empties or drains
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else if (pop) begin
            out_valid_o <= 1'b1;
            out_data_o  <= mem[rd_ptr_ff];
        end else if (out_ready_i) begin
            out_valid_o <= 1'b0;
        end
    end

endmodule : sasp_fifo

module sasp_top
    import sasp_pkg::*;
#(
    parameter int SAMPLE = `SASP_SAMPLE_BITS,
    parameter int SLOT   = `SASP_SLOT_BITS,
    parameter int DEPTH  = `SASP_FIFO_DEPTH
) (
    // system clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    // audio port configuration setting
    input  wire logic              audio_sel_i,
    input  wire logic              cfg_master_i,
    input  wire sasp_fmt_t         cfg_format_i,
    // transmit samples, left in upper half
    input  wire logic              tx_valid_i,
    input  wire logic [2*SAMPLE-1:0] tx_data_i,
    output logic                   tx_ready_o,
    // received samples, left in upper half
    output logic                   rx_valid_o,
    output logic [2*SAMPLE-1:0]    rx_data_o,
    input  wire logic              rx_ready_i,
    // error pulses
    output logic                   tx_underrun_o,
    output logic                   rx_overrun_o,
    // shared serial pins
    input  wire logic              sck_i,
    output logic                   sck_o,
    output logic                   sck_oe_o,
    input  wire logic              ws_i,
    output logic                   ws_o,
    output logic                   ws_oe_o,
    output logic                   sd_out_o,
    output logic                   sd_out_oe_o,
    input  wire logic              sd_in_i
);
    localparam int PW = $clog2(SLOT);
    localparam int IW = $clog2(SAMPLE);
    localparam int DW = 2*SAMPLE;
    localparam int HALF = `SASP_SCK_HALF_CYC;
    localparam logic [PW-1:0] LAST_POS = PW'(SLOT-1);
    localparam logic [7:0] HALF_M1 = 8'(HALF-1);

    function automatic logic [PW-1:0] win_start(sasp_fmt_t f);
        case (f)
            SASP_FMT_I2S: win_start = PW'(1);
            SASP_FMT_LJ:  win_start = '0;
            default:      win_start = PW'(SLOT-SAMPLE);
        endcase
    endfunction : win_start

    function automatic logic in_win(logic [PW-1:0] p, sasp_fmt_t f);
        logic [PW:0] s;
        s = {1'b0, win_start(f)};
        in_win = ({1'b0, p} >= s) && ({1'b0, p} <= s + (PW+1)'(SAMPLE-1));
    endfunction : in_win

    function automatic logic [IW-1:0] bit_idx(logic [PW-1:0] p,
                                              sasp_fmt_t f);
        bit_idx = IW'(SAMPLE-1) - IW'(p - win_start(f));
    endfunction : bit_idx

    // system side: configuration, clock generation, pin enables
    logic            sel_ff, master_ff;
    sasp_fmt_t       fmt_ff;
    logic [7:0]      div_cnt_ff;
    logic            tx_fvalid, tx_fready, rx_push, rx_fready;
    logic [DW-1:0]   tx_fdata;
    logic            tx_req_ff, tx_ack_m_ff, tx_ack_s_ff;
    logic [DW-1:0]   tx_hold_ff;
    logic            rx_req_m_ff, rx_req_s_ff, rx_ack_ff;
    logic [2:0]      unf_sync_ff, ovf_sync_ff;
    // link-side flops that the system side reads through handshakes
    logic            rx_req_ff, tx_ack_ff, unf_tgl_ff, ovf_tgl_ff;
    logic [DW-1:0]   rx_hold_ff;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sel_ff    <= 1'b0;
            master_ff <= 1'b0;
            fmt_ff    <= SASP_FMT_I2S;
        end else begin
            sel_ff    <= audio_sel_i;
            master_ff <= cfg_master_i;
            fmt_ff    <= cfg_format_i;
        end
    end

    // pins driven only when selected; clock and select only as master
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sck_oe_o    <= 1'b0;
            ws_oe_o     <= 1'b0;
            sd_out_oe_o <= 1'b0;
        end else begin
            sck_oe_o    <= sel_ff && master_ff;
            ws_oe_o     <= sel_ff && master_ff;
            sd_out_oe_o <= sel_ff;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !(sel_ff && master_ff)) begin
            div_cnt_ff <= '0;
            sck_o      <= 1'b0;
        end else if (div_cnt_ff == HALF_M1) begin
            div_cnt_ff <= '0;
            sck_o      <= ~sck_o;
        end else begin
            div_cnt_ff <= div_cnt_ff + 8'h01;
        end
    end

    sasp_fifo #(.W(DW), .D(DEPTH)) u_tx_fifo (
        .clk_i      (sys_clk_i),
        .rst_i      (reset_i),
        .in_valid_i (tx_valid_i),
        .in_data_i  (tx_data_i),
        .in_ready_o (tx_ready_o),
        .out_valid_o(tx_fvalid),
        .out_data_o (tx_fdata),
        .out_ready_i(tx_fready)
    );

    // tx word handed to the link by a toggle handshake
    // handshakes restart with the link, which is held in reset when deselected
    assign tx_fready = sel_ff && (tx_req_ff == tx_ack_s_ff);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !sel_ff) begin
            tx_req_ff   <= 1'b0;
            tx_hold_ff  <= '0;
            tx_ack_m_ff <= 1'b0;
            tx_ack_s_ff <= 1'b0;
        end else begin
            tx_ack_m_ff <= tx_ack_ff;
            tx_ack_s_ff <= tx_ack_m_ff;
            if (tx_fvalid && tx_fready) begin
                tx_hold_ff <= tx_fdata;
                tx_req_ff  <= ~tx_req_ff;
            end
        end
    end

    assign rx_push = (rx_req_s_ff != rx_ack_ff);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !sel_ff) begin
            rx_req_m_ff <= 1'b0;
            rx_req_s_ff <= 1'b0;
            rx_ack_ff   <= 1'b0;
        end else begin
            rx_req_m_ff <= rx_req_ff;
            rx_req_s_ff <= rx_req_m_ff;
            if (rx_push && rx_fready) rx_ack_ff <= ~rx_ack_ff;
        end
    end

    sasp_fifo #(.W(DW), .D(DEPTH)) u_rx_fifo (
        .clk_i      (sys_clk_i),
        .rst_i      (reset_i),
        .in_valid_i (rx_push),
        .in_data_i  (rx_hold_ff),
        .in_ready_o (rx_fready),
        .out_valid_o(rx_valid_o),
        .out_data_o (rx_data_o),
        .out_ready_i(rx_ready_i)
    );

    // link error toggles become one-cycle pulses
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !sel_ff) begin
            unf_sync_ff   <= '0;
            ovf_sync_ff   <= '0;
            tx_underrun_o <= 1'b0;
            rx_overrun_o  <= 1'b0;
        end else begin
            unf_sync_ff   <= {unf_sync_ff[1:0], unf_tgl_ff};
            ovf_sync_ff   <= {ovf_sync_ff[1:0], ovf_tgl_ff};
            tx_underrun_o <= unf_sync_ff[2] != unf_sync_ff[1];
            rx_overrun_o  <= ovf_sync_ff[2] != ovf_sync_ff[1];
        end
    end

    // link side, clocked by the serial clock pin
    logic              lrst_m_ff, lrst_ff;
    sasp_fmt_t         fmt_m_ff, fmt_l_ff;
    logic              ws_q_ff;
    logic [PW-1:0]     pos_ff, nxt_pos;
    logic [SAMPLE-1:0] rx_sh_ff, nxt_sh, rx_left_ff;
    logic              rx_ack_m_ff, rx_ack_s_ff;
    logic [IW:0]       rx_nbits_ff;
    logic              tx_req_m_ff, tx_req_s_ff;
    logic              lock_ff, rx_win;
    logic [DW-1:0]     tx_word_ff, tx_src;
    logic [PW-1:0]     tx_p;
    logic              left_nxt, frame_start, tx_win;

    always_ff @(posedge sck_i) begin
        lrst_m_ff <= reset_i || !sel_ff;
        lrst_ff   <= lrst_m_ff;
        fmt_m_ff  <= fmt_ff;
        fmt_l_ff  <= fmt_m_ff;
    end

    // position restarts when word select changes level
    assign nxt_pos = (ws_i != ws_q_ff) ? '0 : pos_ff + PW'(1);
    assign nxt_sh  = {rx_sh_ff[SAMPLE-2:0], sd_in_i};
    // no word counts before the first select change fixes the position
    assign rx_win  = (lock_ff || ws_i != ws_q_ff) &&
                     in_win(nxt_pos, fmt_l_ff);

    always_ff @(posedge sck_i) begin
        if (lrst_ff) begin
            ws_q_ff     <= 1'b0;
            pos_ff      <= '0;
            rx_sh_ff    <= '0;
            rx_nbits_ff <= '0;
            lock_ff     <= 1'b0;
        end else begin
            ws_q_ff <= ws_i;
            pos_ff  <= nxt_pos;
            if (ws_i != ws_q_ff) lock_ff <= 1'b1;
            if (rx_win) begin
                rx_sh_ff    <= nxt_sh;
                rx_nbits_ff <= (nxt_pos == win_start(fmt_l_ff))
                             ? (IW+1)'(1) : rx_nbits_ff + (IW+1)'(1);
            end
        end
    end

    // word complete at the last window bit; channel from select level
    always_ff @(posedge sck_i) begin
        if (lrst_ff) begin
            rx_left_ff  <= '0;
            rx_hold_ff  <= '0;
            rx_req_ff   <= 1'b0;
            ovf_tgl_ff  <= 1'b0;
            rx_ack_m_ff <= 1'b0;
            rx_ack_s_ff <= 1'b0;
        end else begin
            rx_ack_m_ff <= rx_ack_ff;
            rx_ack_s_ff <= rx_ack_m_ff;
            if (rx_win && bit_idx(nxt_pos, fmt_l_ff) == '0) begin
                if (ws_i == (fmt_l_ff != SASP_FMT_I2S)) begin
                    rx_left_ff <= nxt_sh;
                end else if (rx_req_ff == rx_ack_s_ff) begin
                    rx_hold_ff <= {rx_left_ff, nxt_sh};
                    rx_req_ff  <= ~rx_req_ff;
                end else begin
                    ovf_tgl_ff <= ~ovf_tgl_ff;
                end
            end
        end
    end

    // predicted position of the bit launched for the next rising edge
    always_comb begin
        tx_p = (pos_ff == LAST_POS) ? '0 : pos_ff + PW'(1);
        left_nxt = (ws_q_ff ^ (tx_p == '0)) == (fmt_l_ff != SASP_FMT_I2S);
        frame_start = lock_ff && (tx_p == '0) && left_nxt;
        tx_win = in_win(tx_p, fmt_l_ff);
        tx_src = tx_word_ff;
        if (frame_start) begin
            tx_src = (tx_req_s_ff != tx_ack_ff) ? tx_hold_ff : '0;
        end
    end

    always_ff @(negedge sck_i) begin
        if (lrst_ff) begin
            tx_req_m_ff <= 1'b0;
            tx_req_s_ff <= 1'b0;
            tx_ack_ff   <= 1'b0;
            unf_tgl_ff  <= 1'b0;
            tx_word_ff  <= '0;
        end else begin
            tx_req_m_ff <= tx_req_ff;
            tx_req_s_ff <= tx_req_m_ff;
            tx_word_ff  <= tx_src;
            if (frame_start && tx_req_s_ff != tx_ack_ff) begin
                tx_ack_ff <= ~tx_ack_ff;
            end else if (frame_start) begin
                unf_tgl_ff <= ~unf_tgl_ff;
            end
        end
    end

    always_ff @(negedge sck_i) begin
        if (lrst_ff) begin
            ws_o     <= 1'b0;
            sd_out_o <= 1'b0;
        end else begin
            if (tx_p == '0) ws_o <= ~ws_q_ff;
            if (tx_win) begin
                sd_out_o <= left_nxt
                    ? tx_src[SAMPLE + 32'(bit_idx(tx_p, fmt_l_ff))]
                    : tx_src[bit_idx(tx_p, fmt_l_ff)];
            end else begin
                sd_out_o <= 1'b0;
            end
        end
    end

    // checks
    a_oe_when_desel: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !sel_ff |=> !sd_out_oe_o && !sck_oe_o && !ws_oe_o)
        else $error("pins driven while deselected");
    a_slave_no_drive: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (sel_ff && !master_ff) |=> !sck_oe_o && !ws_oe_o)
        else $error("slave drives clock or select");
    a_sck_half_len: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (sck_oe_o && $changed(sck_o)) |-> $past(div_cnt_ff) == HALF_M1)
        else $error("clock half period wrong");
    a_rx_word_len: assert property (@(posedge sck_i) disable iff (lrst_ff)
        (rx_win && bit_idx(nxt_pos, fmt_l_ff) == '0)
        |=> rx_nbits_ff == (IW+1)'(SAMPLE))
        else $error("word not sixteen bits");
    a_i2s_msb_pos: assert property (@(posedge sck_i) disable iff (lrst_ff)
        (fmt_l_ff == SASP_FMT_I2S && ws_i != ws_q_ff)
        ##1 (ws_i == ws_q_ff) |=> rx_nbits_ff == (IW+1)'(1))
        else $error("msb not one clock after select");
    a_rx_sample_pin: assert property (@(posedge sck_i) disable iff (lrst_ff)
        rx_win |=> rx_sh_ff[0] == $past(sd_in_i))
        else $error("input bit not taken at rise");
    a_tx_quiet_out: assert property (@(negedge sck_i) disable iff (lrst_ff)
        !tx_win |=> !sd_out_o)
        else $error("data outside sample window");
    a_ws_steady: assert property (@(negedge sck_i) disable iff (lrst_ff)
        (tx_p != '0) |=> $stable(ws_o))
        else $error("select moved inside slot");
    a_ws_toggle: assert property (@(negedge sck_i) disable iff (lrst_ff)
        (tx_p == '0 && ws_o == ws_q_ff) |=> ws_o != $past(ws_o))
        else $error("select missed slot change");
    a_rj_window: assert property (@(posedge sck_i) disable iff (lrst_ff)
        (fmt_l_ff == SASP_FMT_RJ && in_win(nxt_pos, fmt_l_ff))
        |-> nxt_pos >= PW'(SLOT-SAMPLE))
        else $error("right justified window wrong");

endmodule : sasp_top

`default_nettype wire

// [dv/sasp_codec.sv]
// far audio codec: clock source in device slave mode, data partner always
// assumes the bench feeds it the resolved wire levels of the serial link
`timescale 1ns/1ns
`default_nettype none

module sasp_codec
    import sasp_pkg::*;
(
    // resolved link wires
    input  wire logic      sck_w_i,
    input  wire logic      ws_w_i,
    input  wire logic      sd_out_i,
    output logic           sd_in_o,
    // control from the bench
    input  wire logic      run_i,
    input  wire logic      chk_i,
    input  wire sasp_fmt_t fmt_i,
    // own clock and word select
    output logic           sck_o,
    output logic           ws_o
);
    logic [31:0] got_q[$];
    logic [31:0] cap;
    logic [31:0] word;
    logic        ws_last;
    int          pos;
    int          nframe;
    int          err_n;

    // bit of the 16-bit sample carried at a slot position, -1 outside
    function automatic int idx(input sasp_fmt_t f, input int p);
        if (f == SASP_FMT_I2S) return (p >= 1 && p <= 16) ? 16 - p : -1;
        if (f == SASP_FMT_LJ) return (p <= 15) ? 15 - p : -1;
        return (p >= 16) ? 31 - p : -1;
    endfunction : idx

    // left channel lives in the upper half of a word
    function automatic int lane(input sasp_fmt_t f, input logic w,
                                input int b);
        return (((f == SASP_FMT_I2S) ? !w : w) ? b + 16 : b);
    endfunction : lane

    initial begin
        sck_o = 1'b0;
        ws_o = 1'b1;
        sd_in_o = 1'b0;
        pos = 0;
        nframe = 0;
        err_n = 0;
        word = '0;
        #3;
        forever begin
            wait (run_i);
            for (int k = 0; k < 32 && run_i; k++) begin
                #62 sck_o = 1'b1;
                #63 sck_o = 1'b0;
            end
            #1 ws_o = !ws_o;
        end
    end

    always @(posedge sck_w_i) begin
        int b;
        pos = (ws_w_i !== ws_last) ? 0 : pos + 1;
        ws_last = ws_w_i;
        b = idx(fmt_i, pos);
        if (pos == 0 && lane(fmt_i, ws_w_i, 0) == 16)
            got_q.push_back(cap);
        if (b >= 0)
            cap[lane(fmt_i, ws_w_i, b)] = sd_out_i;
        else if (chk_i && sd_out_i !== 1'b0)
            err_n++;
    end

    // next bit launched just after the falling edge
    always @(negedge sck_w_i) begin
        int b;
        // after the select change that follows the falling edge
        #2;
        b = (ws_w_i !== ws_last) ? 0 : pos + 1;
        if (b == 0 && lane(fmt_i, ws_w_i, 0) == 16) begin
            nframe++;
            word = {16'h9000 + 16'(nframe), 16'h6000 + 16'(nframe)};
        end
        b = idx(fmt_i, b);
        sd_in_o = (b >= 0) ? word[lane(fmt_i, ws_w_i, b)] : !sd_in_o;
    end

    always @(sd_out_i)
        if (chk_i && sck_w_i === 1'b1)
            err_n++;

    always @(ws_w_i)
        if (chk_i && sck_w_i === 1'b1)
            err_n++;
endmodule : sasp_codec

`default_nettype wire

// [dv/sasp_top_tb.sv]
// self-checking bench of the stereo audio serial port
// assumes the design sources and the codec model are compiled before it
`timescale 1ns/1ns
`include "sasp_defs.svh"
`default_nettype none

module sasp_top_tb;
    import sasp_pkg::*;

    localparam int HALF_NS = `SASP_SCK_HALF_CYC * 8;
    localparam int DEPTH   = `SASP_FIFO_DEPTH;

    logic        sys_clk_i, reset_i, audio_sel_i, cfg_master_i;
    sasp_fmt_t   cfg_format_i;
    logic        tx_valid_i, tx_ready_o, rx_valid_o, rx_ready_i;
    logic [31:0] tx_data_i, rx_data_o;
    logic        tx_underrun_o, rx_overrun_o;
    logic        sck_o, sck_oe_o, ws_o, ws_oe_o, sd_out_o, sd_out_oe_o;
    logic        c_sck, c_ws, c_sd, run, chk;
    wire logic   sck_w = sck_oe_o ? sck_o : c_sck;
    wire logic   ws_w  = ws_oe_o ? ws_o : c_ws;
    int          bad_count = 0;
    int          checks = 0;
    int          und_n = 0;
    int          ovr_n = 0;
    logic [31:0] rx_q[$];

    sasp_top i_sasp_top (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .audio_sel_i(audio_sel_i), .cfg_master_i(cfg_master_i),
        .cfg_format_i(cfg_format_i), .tx_valid_i(tx_valid_i),
        .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o),
        .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
        .rx_ready_i(rx_ready_i), .tx_underrun_o(tx_underrun_o),
        .rx_overrun_o(rx_overrun_o), .sck_i(sck_w), .sck_o(sck_o),
        .sck_oe_o(sck_oe_o), .ws_i(ws_w), .ws_o(ws_o), .ws_oe_o(ws_oe_o),
        .sd_out_o(sd_out_o), .sd_out_oe_o(sd_out_oe_o), .sd_in_i(c_sd));

    sasp_codec i_sasp_codec (
        .sck_w_i(sck_w), .ws_w_i(ws_w), .sd_out_i(sd_out_o),
        .sd_in_o(c_sd), .run_i(run), .chk_i(chk),
        .fmt_i(cfg_format_i), .sck_o(c_sck), .ws_o(c_ws));

    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (tx_underrun_o === 1'b1) und_n++;
        if (rx_overrun_o === 1'b1) ovr_n++;
        if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1)
            rx_q.push_back(rx_data_o);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : cyc

    // leaves valid high; the caller lowers it
    task automatic push(input logic [31:0] w, output logic ok);
        tx_valid_i = 1'b1;
        tx_data_i = w;
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge sys_clk_i);
            ok = (tx_ready_o === 1'b1);
        end
        @(negedge sys_clk_i);
    endtask : push

    // reconfigure only while deselected, codec clocking the link reset
    task automatic setup(input logic master, input sasp_fmt_t fmt);
        audio_sel_i = 1'b0;
        run = 1'b1;
        cyc(4);
        cfg_master_i = master;
        cfg_format_i = fmt;
        cyc(100);
        check({sck_oe_o, ws_oe_o, sd_out_oe_o}, 0, "pins free");
        run = !master;
        cyc(40);
        audio_sel_i = 1'b1;
        cyc(400);
        check(sd_out_oe_o, 1, "data out driven");
        check({sck_oe_o, ws_oe_o}, {2{master}}, "clock driven");
    endtask : setup

    task automatic t_reset;
        check({sck_oe_o, ws_oe_o, sd_out_oe_o, tx_ready_o, rx_valid_o}, 0,
              "idle in reset");
        reset_i = 1'b0;
        cyc(2);
        check(tx_ready_o, 1, "ready after reset");
    endtask : t_reset

    task automatic t_stream(input logic master, input sasp_fmt_t fmt);
        int          fr, u, k;
        logic [31:0] w[3];
        logic        ok;
        time         t0;
        fr = master ? 4 * `SASP_SLOT_BITS * `SASP_SCK_HALF_CYC : 1000;
        setup(master, fmt);
        u = und_n;
        cyc(2 * fr);
        check(32'(und_n > u), 1, "zeros when empty");
        i_sasp_codec.got_q.delete();
        rx_q.delete();
        chk = 1'b1;
        for (int i = 0; i < 3; i++) begin
            w[i] = 32'h8e714a30 + 32'(i) * 32'h01010101 + 32'(fmt);
            push(w[i], ok);
        end
        tx_valid_i = 1'b0;
        cyc(5 * fr);
        chk = 1'b0;
        k = 0;
        while (k < i_sasp_codec.got_q.size() &&
               i_sasp_codec.got_q[k] !== w[0]) k++;
        check(32'(k + 2 < i_sasp_codec.got_q.size()), 1, "tx seen");
        for (int i = 1; i < 3; i++)
            check(i_sasp_codec.got_q[k + i], w[i], "tx word");
        check(32'(rx_q.size() >= 4), 1, "rx words");
        check(32'(rx_q[2][31:28]), 32'h9, "rx left upper");
        for (int i = 2; i + 1 < rx_q.size(); i++)
            check(rx_q[i + 1] - rx_q[i], 32'h00010001, "rx order");
        check(i_sasp_codec.err_n, 0, "edge use");
        if (master) begin
            @(posedge sck_o);
            t0 = $time;
            @(posedge sck_o);
            check(32'($time - t0), 2 * HALF_NS, "sck period");
            @(ws_o);
            t0 = $time;
            @(ws_o);
            check(32'($time - t0), `SASP_SLOT_BITS * 2 * HALF_NS,
                  "ws half period");
            cyc(1);
        end
    endtask : t_stream

    // tx fills with the link stopped, rx overruns with no taker
    task automatic t_fill;
        int   n, u, o;
        logic ok;
        setup(1'b0, SASP_FMT_LJ);
        run = 1'b0;
        rx_ready_i = 1'b0;
        cyc(40);
        n = 0;
        ok = 1'b1;
        while (ok && n < 24) begin
            push(32'h5a000000 + 32'(n), ok);
            if (ok) n++;
        end
        tx_valid_i = 1'b0;
        check(32'(n >= DEPTH && n <= DEPTH + 2), 1, "fill depth");
        check(tx_ready_o, 0, "full refuses");
        u = und_n;
        o = ovr_n;
        run = 1'b1;
        cyc(22 * 1000);
        check(32'(ovr_n > o), 1, "rx overrun");
        check(32'(und_n > u), 1, "tx drained");
        rx_q.delete();
        rx_ready_i = 1'b1;
        cyc(40);
        check(32'(rx_q.size() >= DEPTH + 2 && rx_q.size() <= DEPTH + 3), 1,
              "rx depth");
    endtask : t_fill

    initial begin
        reset_i = 1'b1;
        audio_sel_i = 1'b0;
        cfg_master_i = 1'b0;
        cfg_format_i = SASP_FMT_I2S;
        tx_valid_i = 1'b0;
        tx_data_i = '0;
        rx_ready_i = 1'b1;
        run = 1'b1;
        chk = 1'b0;
        cyc(20);
        t_reset;
        for (int m = 0; m < 2; m++)
            for (int f = 0; f < 3; f++)
                t_stream(m[0], sasp_fmt_t'(3'b001 << f));
        t_fill;
        stop_test;
    end

    initial begin
        #760000;
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test;
    end
endmodule : sasp_top_tb

`default_nettype wire
